// ==== pjkl_pkg.sv ====
// Package for the port J/K/L alternate-function override block
// Notes on behaviour
// R1: Port J bits 6..3 are pin-change sources 15..12 and bits 2..0 are sources 11..9, all in group 1.
// R2: A port J input buffer is forced on when its mask bit and the group 1 enable are both set; here bit 7 never is.
// R3: Port K bits 7..0 are sources 23..16 in group 2, buffer forced on by mask and group 2 enable.
// R4: Port K pin n feeds analog converter channel n plus 8.
// R5: The port J bit 2 direction bit makes the serial external clock an output when set.
// R6: The serial external clock on port J bit 2 acts only in synchronous serial operation.
// R7: An enabled serial 3 receiver forces port J bit 0 to input regardless of its direction bit.
// R8: Then the bit 0 pull-up is on exactly when the output bit is one and pull-ups are not disabled.
// R9: An enabled serial 3 transmitter turns bit 1 pull-up off, makes it output and drives tx data.
// R10: Port J pin inputs feed pin-change logic; bit 2 also the serial clock, bit 0 the rx data.
// R11: Port L bit 5 carries timer 5 compare C when its direction bit is output and compare enabled.
// R12: Port L bit 4 carries timer 5 compare B when its direction bit is output and compare enabled.
// R13: The timer 5 compare pins also carry the PWM waveform in PWM modes.
// R14: Port L bit 2 provides timer 5 external counter clock input.
// R15: Port L bit 1 delivers its level to timer 5 capture trigger.
// R16: Port L bit 0 delivers its level to timer 4 capture trigger.
// R17: The global pull-up disable bit switches off every port pull-up; here it only clears the port J bit 0 override pull-up value.
package pjkl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [3:0] PJKL_OFF_CTRL = 4'h0;
    localparam logic [3:0] PJKL_OFF_STAT = 4'h4;
    localparam logic [3:0] PJKL_OFF_MASK = 4'h8;
    localparam logic [3:0] PJKL_OFF_PIN = 4'hc;

    // Control register fields
    localparam int PJKL_CTRL_GRP1 = 0;
    localparam int PJKL_CTRL_GRP2 = 1;
    localparam int PJKL_CTRL_PUD = 2;
    localparam logic [31:0] PJKL_CTRL_RESET = 32'h0000_0000;

    // Status/mask fields: pin changes of J then K
    localparam int PJKL_STAT_J_LSB = 0;
    localparam int PJKL_STAT_K_LSB = 8;
    localparam logic [15:0] PJKL_STAT_RESET = 16'h0000;
    localparam logic [15:0] PJKL_IMASK_RESET = 16'h0000;

    // Converter channel of port K bit 0
    localparam int PJKL_ADC_BASE = 8;

    // Per-pin override bundle
    typedef struct packed {
        logic pu_en;
        logic pu_val;
        logic dir_en;
        logic dir_val;
        logic pv_en;
        logic pv_val;
        logic ib_en;
        logic ib_val;
    } pjkl_ovr_s;

    // Serial 3 controls
    typedef struct packed {
        logic tx_enable;
        logic rx_enable;
        logic sync_mode;
        logic clk_out_en;
        logic clk_out;
        logic tx_line;
    } pjkl_ser_s;

    // Timer 5 compare outputs
    typedef struct packed {
        logic en_b;
        logic val_b;
        logic en_c;
        logic val_c;
    } pjkl_cmp_s;

    // Block state
    typedef struct packed {
        logic [2:0] ctrl;
        logic [15:0] stat;
        logic [15:0] imask;
        logic [7:0] pj_prev;
        logic [7:0] pk_prev;
        logic [31:0] rdata;
        logic rvalid;
    } pjkl_state_s;

endpackage : pjkl_pkg

// ==== pjkl_override.sv ====
// Alternate-function override logic for ports J, K and L
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ns
module pjkl_override #(
    parameter int NPIN = 8
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    // Port J
    input wire logic [NPIN-1:0] pj_pin_i,
    input wire logic [NPIN-1:0] pj_dir_i,
    input wire logic [NPIN-1:0] pj_out_i,
    input wire logic [NPIN-1:0] pj_mask_i,
    output pjkl_pkg::pjkl_ovr_s [NPIN-1:0] pj_ovr_o,
    // Port K
    input wire logic [NPIN-1:0] pk_pin_i,
    input wire logic [NPIN-1:0] pk_mask_i,
    output pjkl_pkg::pjkl_ovr_s [NPIN-1:0] pk_ovr_o,
    output logic [NPIN-1:0] analog_channels_upper_o,
    // Port L
    input wire logic [NPIN-1:0] pl_pin_i,
    input wire logic [NPIN-1:0] pl_dir_i,
    input wire pjkl_pkg::pjkl_cmp_s timer5_cmp_i,
    output pjkl_pkg::pjkl_ovr_s [NPIN-1:0] pl_ovr_o,
    output logic timer5_compare_c_out_o,
    output logic timer5_compare_b_out_o,
    output logic timer5_ext_clock_in_o,
    output logic timer5_capture_in_o,
    output logic timer4_capture_in_o,
    // Serial unit 3, then the pin-change sources
    input wire pjkl_pkg::pjkl_ser_s serial3_i,
    output logic serial3_ext_clock_o,
    output logic serial3_rx_line_o,
    output logic [23:9] pin_change_source_o
);
    import pjkl_pkg::*;

    pjkl_state_s st;
    pjkl_state_s next_st;

    ////////////////////////////////////////////////////////////////////////////////
    // Override value helper: buffer forced on when sensing is enabled
    function automatic pjkl_ovr_s pc_ovr(input logic sense);
        pjkl_ovr_s o;
        o = '0;
        o.ib_en = sense;
        o.ib_val = 1'b1;
        return o;
    endfunction : pc_ovr

    logic grp1_en;
    logic grp2_en;
    logic global_pullup_disable;
    logic [15:0] change;

    assign grp1_en = st.ctrl[PJKL_CTRL_GRP1];
    assign grp2_en = st.ctrl[PJKL_CTRL_GRP2];
    assign global_pullup_disable = st.ctrl[PJKL_CTRL_PUD];

    ////////////////////////////////////////////////////////////////////////////////
    // Port J overrides
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pj_ovr_o[i] = pc_ovr(pj_mask_i[i] & grp1_en); // R2
        end
        pj_ovr_o[7] = '0; // Bit 7 has no alternate function
        // Clock driven out only in synchronous mode with direction set
        pj_ovr_o[2].dir_en = serial3_i.sync_mode & serial3_i.clk_out_en & pj_dir_i[2]; // R5 R6
        pj_ovr_o[2].dir_val = 1'b1;
        pj_ovr_o[2].pv_en = serial3_i.sync_mode & serial3_i.clk_out_en & pj_dir_i[2]; // R5 R6
        pj_ovr_o[2].pv_val = serial3_i.clk_out;
        pj_ovr_o[1].pu_en = serial3_i.tx_enable; // R9
        pj_ovr_o[1].pu_val = 1'b0;
        pj_ovr_o[1].dir_en = serial3_i.tx_enable; // R9
        pj_ovr_o[1].dir_val = 1'b1;
        pj_ovr_o[1].pv_en = serial3_i.tx_enable;
        pj_ovr_o[1].pv_val = serial3_i.tx_line; // R9
        pj_ovr_o[0].pu_en = serial3_i.rx_enable; // R7
        pj_ovr_o[0].pu_val = pj_out_i[0] & ~global_pullup_disable; // R8 R17
        pj_ovr_o[0].dir_en = serial3_i.rx_enable; // R7
        pj_ovr_o[0].dir_val = 1'b0;
        pj_ovr_o[0].pv_en = 1'b0;
        pj_ovr_o[0].pv_val = 1'b0;
    end

    // Serial inputs from the pin buffers; the clock passes only in sync mode with bit 2 an input
    assign serial3_ext_clock_o = serial3_i.sync_mode & ~pj_dir_i[2] & pj_pin_i[2]; // R6 R10
    assign serial3_rx_line_o = pj_pin_i[0]; // R10

    ////////////////////////////////////////////////////////////////////////////////
    // Port K overrides and analog routing
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pk_ovr_o[i] = pc_ovr(pk_mask_i[i] & grp2_en); // R3
        end
    end
    assign analog_channels_upper_o = pk_pin_i; // R4: bit n is channel n+PJKL_ADC_BASE

    // Gated pin-change sources, J bits 6..0 then K
    assign pin_change_source_o = {pk_pin_i & pk_mask_i & {NPIN{grp2_en}},
                                  pj_pin_i[6:0] & pj_mask_i[6:0] & {7{grp1_en}}}; // R1 R3

    ////////////////////////////////////////////////////////////////////////////////
    // Port L overrides; compare values carry PWM too
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            pl_ovr_o[i] = '0;
        end
        pl_ovr_o[5].pv_en = timer5_cmp_i.en_c; // R11 R13
        pl_ovr_o[5].pv_val = timer5_cmp_i.val_c;
        pl_ovr_o[4].pv_en = timer5_cmp_i.en_b; // R12 R13
        pl_ovr_o[4].pv_val = timer5_cmp_i.val_b;
    end
    // Pin only drives when software set the direction bit
    assign timer5_compare_c_out_o = pl_dir_i[5] & timer5_cmp_i.en_c & timer5_cmp_i.val_c; // R11
    assign timer5_compare_b_out_o = pl_dir_i[4] & timer5_cmp_i.en_b & timer5_cmp_i.val_b; // R12
    assign timer5_ext_clock_in_o = pl_pin_i[2]; // R14
    assign timer5_capture_in_o = pl_pin_i[1]; // R15
    assign timer4_capture_in_o = pl_pin_i[0]; // R16

    ////////////////////////////////////////////////////////////////////////////////
    // Pin-change event detection, status, registers
    assign change = {pk_pin_i ^ st.pk_prev, pj_pin_i ^ st.pj_prev};

    always_comb begin
        next_st = st;
        next_st.pj_prev = pj_pin_i;
        next_st.pk_prev = pk_pin_i;
        next_st.rvalid = 1'b0;
        if (avs_write_i) begin
            case (avs_address_i)
                PJKL_OFF_CTRL: next_st.ctrl = avs_writedata_i[2:0];
                PJKL_OFF_STAT: next_st.stat = st.stat & ~avs_writedata_i[15:0];
                PJKL_OFF_MASK: next_st.imask = avs_writedata_i[15:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        // Set wins over a same-cycle clear; bit 7 of J is not a source
        next_st.stat = next_st.stat | (change & 16'hff7f & {{8{grp2_en}}, {8{grp1_en}}});
        if (avs_read_i && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            case (avs_address_i)
                PJKL_OFF_CTRL: next_st.rdata = {29'h0, st.ctrl};
                PJKL_OFF_STAT: next_st.rdata = {16'h0, st.stat};
                PJKL_OFF_MASK: next_st.rdata = {16'h0, st.imask};
                PJKL_OFF_PIN: next_st.rdata = {16'h0, pk_pin_i, pj_pin_i};
                default: next_st.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '{ctrl: PJKL_CTRL_RESET[2:0], stat: PJKL_STAT_RESET,
                    imask: PJKL_IMASK_RESET, pj_prev: 8'h00, pk_prev: 8'h00,
                    rdata: 32'h0, rvalid: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    // Reads wait one cycle, writes complete at once
    assign avs_waitrequest_o = avs_read_i & ~st.rvalid;
    assign avs_readdata_o = st.rdata;
    assign irq_o = |(st.stat & st.imask);

endmodule : pjkl_override

// ==== pjkl_assertions.sv ====
// Checker of the port J/K/L override block
`timescale 1ns/1ns
module pjkl_checker #(
    parameter int NPIN = 8
) (
    // Clock, reset, bus handshake
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic avs_read_i,
    input wire logic avs_waitrequest_o,
    // Pin side
    input wire logic [NPIN-1:0] pj_pin_i,
    input wire logic [NPIN-1:0] pj_dir_i,
    input wire logic [NPIN-1:0] pk_pin_i,
    input wire logic [NPIN-1:0] pl_pin_i,
    input wire logic [NPIN-1:0] pl_dir_i,
    input wire pjkl_pkg::pjkl_cmp_s timer5_cmp_i,
    input wire pjkl_pkg::pjkl_ser_s serial3_i,
    input wire pjkl_pkg::pjkl_ovr_s [NPIN-1:0] pj_ovr_o,
    input wire pjkl_pkg::pjkl_ovr_s [NPIN-1:0] pk_ovr_o,
    input wire logic [NPIN-1:0] analog_channels_upper_o,
    input wire logic timer5_compare_b_out_o,
    input wire logic serial3_ext_clock_o,
    input wire logic [23:9] pin_change_source_o
);
    import pjkl_pkg::*;
    logic [NPIN-1:0] j_ib;
    logic [NPIN-1:0] k_ib;
    ////////////////////////////////////////////////////////////////////////////////
    // Buffer-enable vectors, so sensing can be tied to them
    always_comb begin
        for (int n = 0; n < NPIN; n++) begin
            j_ib[n] = pj_ovr_o[n].ib_en;
            k_ib[n] = pk_ovr_o[n].ib_en;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Read answer: one wait cycle, then data
    sequence s_wait_then_data;
        avs_waitrequest_o ##1 !avs_waitrequest_o;
    endsequence
    a_read_answer: assert property ($rose(avs_read_i) |-> s_wait_then_data)
        else $error("read answer not after one wait cycle");
    a_j_sense: assert property (pin_change_source_o[15:9] == (pj_pin_i[6:0] & j_ib[6:0]))
        else $error("port J sensing wrong");
    a_k_sense: assert property (pin_change_source_o[23:16] == (pk_pin_i & k_ib))
        else $error("port K sensing wrong");
    a_adc_map: assert property (analog_channels_upper_o == pk_pin_i)
        else $error("analog channel map wrong");
    a_rx_input: assert property (serial3_i.rx_enable |-> pj_ovr_o[0].dir_en && !pj_ovr_o[0].dir_val)
        else $error("receive pin not forced to input");
    a_tx_drive: assert property (serial3_i.tx_enable |-> pj_ovr_o[1].dir_en && pj_ovr_o[1].pu_en
        && pj_ovr_o[1].pv_en && pj_ovr_o[1].dir_val && !pj_ovr_o[1].pu_val
        && pj_ovr_o[1].pv_val == serial3_i.tx_line)
        else $error("transmit pin not driven");
    a_cmp_b: assert property (timer5_compare_b_out_o == (pl_dir_i[4] & timer5_cmp_i.en_b & timer5_cmp_i.val_b))
        else $error("compare B output wrong");
    a_ext_clock: assert property (serial3_ext_clock_o == (serial3_i.sync_mode & ~pj_dir_i[2] & pj_pin_i[2]))
        else $error("serial clock input wrong");
endmodule : pjkl_checker
bind pjkl_override pjkl_checker #(.NPIN(NPIN)) i_pjkl_checker (.*);

// ==== pjkl_board.sv ====
// Board model that drives the port pins
`timescale 1ns/1ns
module pjkl_board (
    // Board levels and port J overrides
    input wire logic [23:0] lvl_i,
    input wire pjkl_pkg::pjkl_ovr_s [7:0] pj_ovr_i,
    // Pin levels seen by the block
    output logic [7:0] pj_pin_o,
    output logic [7:0] pk_pin_o,
    output logic [7:0] pl_pin_o
);
    import pjkl_pkg::*;
    // An overridden output wins the wire over the board source
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            pj_pin_o[n] = (pj_ovr_i[n].dir_en & pj_ovr_i[n].dir_val & pj_ovr_i[n].pv_en) ?
                pj_ovr_i[n].pv_val : lvl_i[n];
        end
        {pl_pin_o, pk_pin_o} = lvl_i[23:8];
    end
endmodule : pjkl_board

// ==== testbench.sv ====
// Self-checking bench of the port J/K/L override block
`timescale 1ns/1ns
module testbench;
    import pjkl_pkg::*;
    logic clock_i, rst_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
    logic [3:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, q, v;
    logic [7:0] pj_pin_i, pj_dir_i, pj_out_i, pj_mask_i, pk_pin_i, pk_mask_i, pl_pin_i, pl_dir_i;
    logic [7:0] analog_channels_upper_o, ibj, ibk;
    logic [23:0] lvl;
    logic [23:9] pin_change_source_o;
    logic [2:0] ctl;
    pjkl_ovr_s [7:0] pj_ovr_o, pk_ovr_o, pl_ovr_o;
    pjkl_cmp_s timer5_cmp_i;
    pjkl_ser_s serial3_i;
    logic timer5_compare_c_out_o, timer5_compare_b_out_o, timer5_ext_clock_in_o;
    logic timer5_capture_in_o, timer4_capture_in_o, serial3_ext_clock_o, serial3_rx_line_o;
    int n_errors = 0, cmp_count = 0, seed = 71, cyc = 0;
    pjkl_override i_pjkl_override (.*);
    pjkl_board i_pjkl_board (.lvl_i(lvl), .pj_ovr_i(pj_ovr_o), .pj_pin_o(pj_pin_i),
        .pk_pin_o(pk_pin_i), .pl_pin_o(pl_pin_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Bus cycle; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        logic done;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clock_i);
            done = (avs_waitrequest_o === 1'b0);
            q = avs_readdata_o;
        end while (!done);
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        // Idle edge, so a following call never re-raises a strobe in this step
        @(posedge clock_i);
    endtask : bus
    task automatic give_verdict;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    // Clock, and a ceiling against hangs
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
    // Random sweep of controls, then the interrupt path
    initial begin
        rst_i = 1'b1;
        {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i} = '0;
        {pj_dir_i, pj_out_i, pj_mask_i, pk_mask_i, pl_dir_i, lvl} = '0;
        {timer5_cmp_i, serial3_i} = '0;
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        repeat (60) begin
            v = $random(seed);
            bus(1'b1, PJKL_OFF_CTRL, {29'h0, v[2:0]});
            ctl = v[2:0];
            {pj_dir_i, pj_out_i, pj_mask_i, pk_mask_i} <= $random(seed);
            {pl_dir_i, lvl} <= $random(seed);
            {timer5_cmp_i, serial3_i} <= 10'($random(seed));
            @(negedge clock_i);
            for (int n = 0; n < 8; n++) begin
                ibj[n] = pj_ovr_o[n].ib_en;
                ibk[n] = pk_ovr_o[n].ib_en;
            end
            chk(ibj, {1'b0, pj_mask_i[6:0] & {7{ctl[0]}}});
            chk(ibk, pk_mask_i & {8{ctl[1]}});
            chk(analog_channels_upper_o, lvl[15:8]);
            chk(pin_change_source_o[23:16], lvl[15:8] & pk_mask_i & {8{ctl[1]}});
            chk(pin_change_source_o[15:9], pj_pin_i[6:0] & pj_mask_i[6:0] & {7{ctl[0]}});
            chk(pj_ovr_o[2].dir_en, serial3_i.sync_mode & serial3_i.clk_out_en & pj_dir_i[2]);
            chk(serial3_ext_clock_o, serial3_i.sync_mode & ~pj_dir_i[2] & lvl[2]);
            if (serial3_i.tx_enable) chk(pj_pin_i[1], serial3_i.tx_line);
            chk(pl_ovr_o[5], {4'h0, timer5_cmp_i.en_c, timer5_cmp_i.val_c, 2'h0});
            chk(pl_ovr_o[4], {4'h0, timer5_cmp_i.en_b, timer5_cmp_i.val_b, 2'h0});
            chk(timer5_compare_b_out_o, pl_dir_i[4] & timer5_cmp_i.en_b & timer5_cmp_i.val_b);
            if (serial3_i.rx_enable) chk(pj_ovr_o[0].pu_val, pj_out_i[0] & ~ctl[2]);
            chk(timer5_compare_c_out_o, pl_dir_i[5] & timer5_cmp_i.en_c & timer5_cmp_i.val_c);
            chk({timer5_ext_clock_in_o, timer5_capture_in_o, timer4_capture_in_o}, lvl[18:16]);
            chk(serial3_rx_line_o, lvl[0]);
            @(posedge clock_i);
        end
        {serial3_i, lvl} <= '0;
        bus(1'b1, PJKL_OFF_CTRL, 32'h1);
        repeat (2) @(posedge clock_i);
        bus(1'b1, PJKL_OFF_STAT, 32'hffff);
        bus(1'b1, PJKL_OFF_MASK, 32'h1);
        @(negedge clock_i) chk(irq_o, 1'b0);
        lvl <= 24'h1;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i) chk(irq_o, 1'b1);
        @(posedge clock_i);
        bus(1'b0, PJKL_OFF_STAT, 32'h0);
        chk(q, 32'h1);
        bus(1'b1, PJKL_OFF_MASK, 32'h0);
        @(negedge clock_i) chk(irq_o, 1'b0);
        @(posedge clock_i);
        bus(1'b1, PJKL_OFF_STAT, 32'h1);
        bus(1'b0, PJKL_OFF_STAT, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        bus(1'b0, PJKL_OFF_CTRL, 32'h0);
        chk(q, 32'h1);
        give_verdict();
    end
endmodule : testbench
